/* File: rtl/psc_regs.svh */
// Purpose: Offsets, fields, reset values and timing of the companion.
// Assumes: 25 MHz core clock.
// Notes:   Counts above 4096 cycles are overridable module parameters.
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PSC_OFF_FLAGS  8'h09
`define PSC_OFF_DOG    8'h0a
`define PSC_OFF_CMP    8'h0b
`define PSC_OFF_CNTC   8'h0c
`define PSC_OFF_CNT0   8'h0d
`define PSC_OFF_CNT3   8'h10
`define PSC_OFF_SER0   8'h11
`define PSC_OFF_SER7   8'h18
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PSC_FLAG_DOG   7
`define PSC_FLAG_POR   6
`define PSC_KICK       4'ha
`define PSC_DOG_OFF    5'h1f
`define PSC_DOG_RST    8'h1f
`define PSC_CMP_RST    8'h00
`define PSC_CNTC_RST   4'h0
`define PSC_CNTC_SNAP  3
`define PSC_CNTC_CHAIN 2
// ----------------------------------------
// Timing
// ----------------------------------------
`define PSC_CLK_HZ     64'd25000000
`define PSC_HOLD_MS    64'd100
`define PSC_STEP_MS    64'd100
`define PSC_DEB_US     64'd1000
`define PSC_CAL_HZ     64'd512
`define PSC_HOLD_CYC ((`PSC_HOLD_MS*`PSC_CLK_HZ+64'd999)/64'd1000)
`define PSC_STEP_CYC ((`PSC_STEP_MS*`PSC_CLK_HZ+64'd999)/64'd1000)
`define PSC_DEB_CYC  ((`PSC_DEB_US*`PSC_CLK_HZ+64'd999999)/64'd1000000)
`define PSC_CALH_CYC (`PSC_CLK_HZ/(64'd2*`PSC_CAL_HZ))
`endif

/* File: rtl/psc_pkg.sv */
// Purpose: Types shared by the companion and its bench.
// Assumes: Nothing.
// Notes:   Request and answer travel between the link and core clocks.
package psc_pkg;
  typedef enum logic [1:0] {RS_IDLE, RS_LOW, RS_HOLD} psc_rst_st_t;
  typedef struct packed {
    logic        companion; // 1: register space, 0: memory array
    logic        write;
    logic [15:0] addr;
    logic [7:0]  data;
  } psc_req_t;
  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } psc_resp_t;
endpackage

/* File: rtl/psc_companion.sv */
// Purpose: Supervisor, watchdog, counters, serial id, array protect.
// Assumes: A two-wire engine on link_clk_in hands over decoded bytes.
// Notes:   Memory array is outside; it gets gated write strobes.
`timescale 1ns/1ps
`include "psc_regs.svh"
module psc_companion import psc_pkg::*; #(
  parameter int unsigned HOLD_CYC    = int'(`PSC_HOLD_CYC),
  parameter int unsigned STEP_CYC    = int'(`PSC_STEP_CYC),
  parameter int unsigned DEB_CYC     = int'(`PSC_DEB_CYC),
  parameter int unsigned CALH_CYC    = int'(`PSC_CALH_CYC),
  parameter int unsigned ARRAY_BYTES = 32768
) (
  input  wire logic      ref_clk_in,        // Core clock
  input  wire logic      nrst_in,           // Async reset, low
  input  wire logic      link_clk_in,       // Bus engine clock
  input  wire logic      link_req_in,       // Request pulse
  input  wire psc_req_t  link_req_data_in,  // Request fields
  output logic           link_busy_out,     // Request in flight
  output logic           link_done_out,     // Answer pulse
  output psc_resp_t      link_resp_out,     // Answer fields
  output logic           mem_we_out,        // Array write strobe
  output logic           mem_re_out,        // Array read strobe
  output logic [15:0]    mem_addr_out,      // Array address
  output logic [7:0]     mem_wdata_out,     // Array write data
  input  wire logic [7:0] mem_rdata_in,     // Array data, same cycle as read strobe
  input  wire logic      supply_low_in,     // Supply below trip
  input  wire logic      pf_below_in,       // Comparator below ref
  input  wire logic      calib_mode_in,     // Calibration mode
  input  wire logic      event_in_one,      // Event input one
  input  wire logic      event_in_two,      // Event input two
  input  wire logic      rst_pin_in,        // Reset pin level
  output logic           rst_pin_out,       // Reset pin drive value
  output logic           rst_pin_oe_out,    // Reset pin drive enable
  output logic           trim_or_powerfail_out, // Shared output
  output logic [1:0]     trip_select_out    // Trip level select
);

  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  psc_req_t   lk_req;
  logic       lk_req_tgl;
  logic       lk_busy;
  logic       lk_done;
  psc_resp_t  lk_resp;
  logic [1:0] lk_ack_sync;
  logic       lk_ack_seen;
  logic       core_ack_tgl;
  psc_resp_t  core_resp;
  wire        lk_ack_new = lk_ack_sync[1] ^ lk_ack_seen;

  // Hold request stable while it crosses
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lk_req     <= '0;
      lk_req_tgl <= 1'b0;
      lk_busy    <= 1'b0;
    end else if (link_req_in && !lk_busy) begin
      lk_req     <= link_req_data_in;
      lk_req_tgl <= ~lk_req_tgl;
      lk_busy    <= 1'b1;
    end else if (lk_ack_new) begin
      lk_busy    <= 1'b0;
    end
  end

  // Answer toggle back from the core
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lk_ack_sync <= 2'b00;
      lk_ack_seen <= 1'b0;
      lk_done     <= 1'b0;
      lk_resp     <= '0;
    end else begin
      lk_ack_sync <= {lk_ack_sync[0], core_ack_tgl};
      lk_ack_seen <= lk_ack_sync[1];
      lk_done     <= lk_ack_new;
      if (lk_ack_new)
        lk_resp <= core_resp;
    end
  end

  assign link_busy_out = lk_busy;
  assign link_done_out = lk_done;
  assign link_resp_out = lk_resp;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [2:0] rq_sync;
  logic [5:0] in_s1;
  logic [5:0] in_s2;
  logic [1:0] ev_prev;

  // Two flops on every outside input
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rq_sync <= 3'b000;
      in_s1   <= 6'h01;
      in_s2   <= 6'h01;
      ev_prev <= 2'b00;
    end else begin
      rq_sync <= {rq_sync[1:0], lk_req_tgl};
      in_s1   <= {supply_low_in, pf_below_in, calib_mode_in,
                  event_in_one, event_in_two, rst_pin_in};
      in_s2   <= in_s1;
      ev_prev <= in_s2[2:1];
    end
  end

  wire supply_s = in_s2[5];
  wire pf_s     = in_s2[4];
  wire calib_s  = in_s2[3];
  wire ev1_s    = in_s2[2];
  wire ev2_s    = in_s2[1];
  wire pin_s    = in_s2[0];
  wire take     = rq_sync[1] ^ rq_sync[2];

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  psc_rst_st_t     st;
  psc_rst_st_t     next_st;
  logic            flag_dog;
  logic            flag_por;
  logic            dog_en;
  logic [4:0]      dog_period;
  logic            id_lock;
  logic [1:0]      prot;
  logic            charge;
  logic [1:0]      trip;
  logic [3:0]      cnt_ctl;
  logic [31:0]     cnt;
  logic [31:0]     snap;
  logic [7:0][7:0] serial;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  localparam logic [16:0] ARR_N   = 17'(ARRAY_BYTES);
  localparam logic [7:0]  DOG_RST = `PSC_DOG_RST; // Named so bits can be picked
  localparam logic [7:0]  CMP_RST = `PSC_CMP_RST;

  // Protected span for a masked array address
  function automatic logic is_prot(input logic [15:0] a,
                                   input logic [1:0]  p);
    logic [16:0] lim;
    lim = 17'h0;
    case (p)
      2'b01:   lim = ARR_N >> 2;
      2'b10:   lim = ARR_N >> 1;
      2'b11:   lim = ARR_N;
      default: lim = 17'h0;
    endcase
    return {1'b0, a} < lim;
  endfunction

  // Companion register read select
  function automatic logic [7:0] reg_rd(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == `PSC_OFF_FLAGS)
      v = {flag_dog, flag_por, 6'h00};
    else if (a == `PSC_OFF_DOG)
      v = {dog_en, 2'b00, dog_period};
    else if (a == `PSC_OFF_CMP)
      v = {id_lock, 2'b00, prot, charge, trip};
    else if (a == `PSC_OFF_CNTC)
      v = {4'h0, cnt_ctl};
    else if (a >= `PSC_OFF_CNT0 && a <= `PSC_OFF_CNT3)
      v = snap[8*(a-`PSC_OFF_CNT0) +: 8];
    else if (a >= `PSC_OFF_SER0 && a <= `PSC_OFF_SER7)
      v = serial[a-`PSC_OFF_SER0];
    return v;
  endfunction

  // Split array and register devices, gate on reset and protection
  wire [15:0] arr_addr = lk_req.addr & 16'(ARRAY_BYTES - 1);
  wire [7:0]  rg_addr  = lk_req.addr[7:0];
  wire        locked   = st != RS_IDLE;
  wire        rq_arr   = !lk_req.companion;
  wire        prot_hit = rq_arr && lk_req.write
                         && is_prot(arr_addr, prot);
  wire        arr_acc  = take && !locked && rq_arr && !prot_hit;
  wire        cmp_wr   = take && !locked && lk_req.companion
                         && lk_req.write;
  wire        wr_flags = cmp_wr && rg_addr == `PSC_OFF_FLAGS;
  wire        wr_dog   = cmp_wr && rg_addr == `PSC_OFF_DOG;
  wire        wr_cmp   = cmp_wr && rg_addr == `PSC_OFF_CMP;
  wire        wr_cntc  = cmp_wr && rg_addr == `PSC_OFF_CNTC;
  wire        cnt_wr   = cmp_wr && rg_addr >= `PSC_OFF_CNT0
                         && rg_addr <= `PSC_OFF_CNT3;
  wire        ser_wr   = cmp_wr && rg_addr >= `PSC_OFF_SER0
                         && rg_addr <= `PSC_OFF_SER7;
  wire        kick     = wr_flags
                         && lk_req.data[3:0] == `PSC_KICK;

  // ----------------------------------------
  // Core answer path
  // ----------------------------------------
  logic       pend;
  logic       resp_ack;
  logic       resp_cmp;
  logic [7:0] cmp_rd;

  // Take a request, answer one cycle later
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend     <= 1'b0;
      resp_ack <= 1'b0;
      resp_cmp <= 1'b0;
      cmp_rd   <= 8'h00;
    end else begin
      pend <= take;
      if (take) begin
        resp_ack <= !locked && !prot_hit;
        resp_cmp <= lk_req.companion;
        cmp_rd   <= reg_rd(rg_addr);
      end
    end
  end

  // Answer fields held until the next request
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      core_resp    <= '0;
      core_ack_tgl <= 1'b0;
    end else if (pend) begin
      core_resp    <= {resp_ack, resp_cmp ? cmp_rd : mem_rdata_in};
      core_ack_tgl <= ~core_ack_tgl;
    end
  end

  // Array strobes, only for allowed accesses
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_we_out    <= 1'b0;
      mem_re_out    <= 1'b0;
      mem_addr_out  <= 16'h0000;
      mem_wdata_out <= 8'h00;
    end else begin
      mem_we_out    <= arr_acc && lk_req.write;
      mem_re_out    <= arr_acc && !lk_req.write;
      mem_addr_out  <= arr_addr;
      mem_wdata_out <= lk_req.data;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic dog_fire;
  logic por_set;

  // Writable control fields
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {dog_en, dog_period} <= {DOG_RST[7], DOG_RST[4:0]};
      {id_lock, prot, charge, trip} <= {CMP_RST[7], CMP_RST[4:0]};
      cnt_ctl <= `PSC_CNTC_RST;
    end else begin
      if (wr_dog)
        {dog_en, dog_period} <= {lk_req.data[7], lk_req.data[4:0]};
      if (wr_cmp) begin
        id_lock <= id_lock | lk_req.data[7];
        {prot, charge, trip} <= lk_req.data[4:0];
      end
      if (wr_cntc)
        cnt_ctl <= lk_req.data[3:0];
    end
  end

  assign trip_select_out = trip;

  // Sticky reset source flags, set beats clear
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag_dog <= 1'b0;
      flag_por <= 1'b1;
    end else begin
      flag_dog <= dog_fire
        | (flag_dog & !(wr_flags && !lk_req.data[`PSC_FLAG_DOG]));
      flag_por <= por_set
        | (flag_por & !(wr_flags && !lk_req.data[`PSC_FLAG_POR]));
    end
  end

  // Serial id bytes, frozen once locked
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in)
      serial <= '0;
    else if (ser_wr && !id_lock)
      serial[rg_addr - `PSC_OFF_SER0] <= lk_req.data;
  end

  // ----------------------------------------
  // Event counters
  // ----------------------------------------
  wire chain = cnt_ctl[`PSC_CNTC_CHAIN];
  wire inc1  = cnt_ctl[0] ? (ev1_s && !ev_prev[1])
                          : (!ev1_s && ev_prev[1]);
  wire inc2  = cnt_ctl[1] ? (ev2_s && !ev_prev[0])
                          : (!ev2_s && ev_prev[0]);
  wire [4:0] cnt_byte = 5'(rg_addr - `PSC_OFF_CNT0) << 3;

  // Count, load from software, or hold during a write
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in)
      cnt <= 32'h0;
    else if (cnt_wr)
      cnt[cnt_byte +: 8] <= lk_req.data;
    else if (chain)
      cnt <= cnt + {31'h0, inc1};
    else begin
      cnt[15:0]  <= cnt[15:0] + {15'h0, inc1};
      cnt[31:16] <= cnt[31:16] + {15'h0, inc2};
    end
  end

  // Capture all four bytes together
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in)
      snap <= 32'h0;
    else if (wr_cntc && lk_req.data[`PSC_CNTC_SNAP])
      snap <= cnt;
  end

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  logic [31:0] hold_cnt;
  logic [31:0] deb_cnt;
  wire man_fire = st == RS_IDLE && !pin_s
                  && deb_cnt == 32'(DEB_CYC - 1);
  wire rst_end  = st == RS_HOLD && next_st == RS_IDLE;
  assign por_set = supply_s && st != RS_LOW;

  // Next state of the reset pin
  always_comb begin
    next_st = st;
    case (st)
      RS_IDLE:
        if (supply_s)
          next_st = RS_LOW;
        else if (dog_fire || man_fire)
          next_st = RS_HOLD;
      RS_LOW:
        if (!supply_s)
          next_st = RS_HOLD;
      RS_HOLD:
        if (supply_s)
          next_st = RS_LOW;
        else if (hold_cnt == 32'(HOLD_CYC - 1))
          next_st = RS_IDLE;
      default:
        next_st = RS_IDLE;
    endcase
  end

  // State, hold timer and pin drive
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st             <= RS_IDLE;
      hold_cnt       <= 32'h0;
      rst_pin_out    <= 1'b0;
      rst_pin_oe_out <= 1'b0;
    end else begin
      st             <= next_st;
      hold_cnt       <= (next_st == RS_HOLD && st == RS_HOLD)
                        ? hold_cnt + 32'h1 : 32'h0;
      rst_pin_out    <= 1'b0;
      rst_pin_oe_out <= next_st != RS_IDLE;
    end
  end

  // Debounce an outside low on the pin
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in)
      deb_cnt <= 32'h0;
    else if (st != RS_IDLE || pin_s || man_fire)
      deb_cnt <= 32'h0;
    else
      deb_cnt <= deb_cnt + 32'h1;
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  logic [31:0] pre_cnt;
  logic [4:0]  dog_ticks;
  logic [4:0]  dog_load;
  wire stopped = dog_load == `PSC_DOG_OFF;
  wire restart = kick || rst_end || st == RS_LOW;
  wire tick    = pre_cnt == 32'(STEP_CYC - 1);
  wire dog_to  = tick && !stopped && 5'(dog_ticks + 5'h1) == dog_load;
  assign dog_fire = dog_to && dog_en && st == RS_IDLE && !supply_s;

  // Tick prescaler and period count, frozen while the loaded period is 1f
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_cnt   <= 32'h0;
      dog_ticks <= 5'h0;
      dog_load  <= DOG_RST[4:0];
    end else if (restart) begin
      pre_cnt   <= 32'h0;
      dog_ticks <= 5'h0;
      if (kick)
        dog_load <= dog_period;
    end else if (!stopped) begin
      pre_cnt   <= tick ? 32'h0 : pre_cnt + 32'h1;
      if (tick)
        dog_ticks <= dog_to ? 5'h0 : dog_ticks + 5'h1;
    end
  end

  // ----------------------------------------
  // Shared power-fail / calibration output
  // ----------------------------------------
  logic [31:0] cal_cnt;
  logic        cal_sq;

  // Square wave and output select
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cal_cnt               <= 32'h0;
      cal_sq                <= 1'b0;
      trim_or_powerfail_out <= 1'b1;
    end else begin
      cal_cnt <= (cal_cnt == 32'(CALH_CYC - 1)) ? 32'h0
                 : cal_cnt + 32'h1;
      if (cal_cnt == 32'(CALH_CYC - 1))
        cal_sq <= ~cal_sq;
      trim_or_powerfail_out <= calib_s ? cal_sq : !pf_s;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  open_write_a: assert property (
    take && !locked && rq_arr && lk_req.write && prot == 2'b00
    |=> mem_we_out)
    else $error("unprotected array write dropped");
  prot_nack_a: assert property (
    take && !locked && prot_hit |=> !mem_we_out ##1 !core_resp.ack)
    else $error("protected write stored or acked");
  supply_rst_a: assert property (
    supply_s |=> rst_pin_oe_out && st == RS_LOW)
    else $error("low supply without reset");
  hold_len_a: assert property (
    $fell(rst_pin_oe_out) |-> $past(hold_cnt) == 32'(HOLD_CYC - 1))
    else $error("reset released early");
  bus_lock_a: assert property (
    take && locked |=> !mem_we_out && !mem_re_out ##1 !core_resp.ack)
    else $error("bus served during reset");
  dog_gate_a: assert property (
    dog_to && !dog_en && st == RS_IDLE && !supply_s && !man_fire
    |=> !rst_pin_oe_out)
    else $error("disabled watchdog reset");
  dog_stop_a: assert property (
    stopped && !restart |=> $stable(pre_cnt) && $stable(dog_ticks))
    else $error("stopped watchdog moved");
  kick_load_a: assert property (
    kick |=> dog_ticks == 5'h0 && dog_load == $past(dog_period))
    else $error("kick did not reload");
  flag_set_a: assert property (
    dog_fire |=> flag_dog && rst_pin_oe_out)
    else $error("watchdog reset not flagged");
  pf_route_a: assert property (
    !calib_s && pf_s |=> !trim_or_powerfail_out)
    else $error("power-fail not driven");
  cal_route_a: assert property (
    calib_s |=> trim_or_powerfail_out == $past(cal_sq))
    else $error("calibration wave missing");
  cnt_inc_a: assert property (
    inc1 && !chain && !cnt_wr |=> cnt[15:0] == $past(cnt[15:0]) + 16'h1)
    else $error("event not counted");
  id_lock_a: assert property (
    id_lock && ser_wr |=> $stable(serial) && id_lock)
    else $error("locked serial changed");

  dog_reset_c: cover property (dog_fire ##[1:3] rst_pin_oe_out);
  man_reset_c: cover property (man_fire);
  prot_nack_c: cover property (take && prot_hit);
  chain_inc_c: cover property (chain && inc1 && !cnt_wr);

endmodule

/* File: tb/psc_mem_model.sv */
// Purpose: Byte array standing behind the companion's memory port.
// Assumes: Read data is wanted while the read strobe is high.
// Notes:   Idle data is the inverse of the last byte read.
`timescale 1ns/1ps
module psc_mem_model (
  input  wire logic        clk_in,   // Core clock
  input  wire logic        we_in,    // Write strobe
  input  wire logic        re_in,    // Read strobe
  input  wire logic [15:0] addr_in,  // Byte address
  input  wire logic [7:0]  wdata_in, // Write data
  output logic [7:0]       rdata_out // Read data
);
  logic [7:0] mem [512];
  logic [7:0] last;
  // Cleared store
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    last = 8'h00;
  end
  // Store on write, remember last byte read
  always @(posedge clk_in) begin
    if (we_in) mem[addr_in[8:0]] <= wdata_in;
    if (re_in) last <= mem[addr_in[8:0]];
  end
  // Data only while the read is strobed
  assign rdata_out = re_in ? mem[addr_in[8:0]] : ~last;
endmodule

/* File: tb/processor_companion_supervisor_test.sv */
// Purpose: Register, protect, supervisor and counter checks.
// Assumes: Shortened hold, tick, debounce and wave counts.
// Notes:   Requests are raised on the falling link clock edge.
`timescale 1ns/1ps
`include "psc_regs.svh"
module processor_companion_supervisor_test import psc_pkg::*;;
  logic        clk = 0, lclk = 0, nrst = 0, req = 0, pin, pv;
  psc_req_t    rq = '0;
  psc_resp_t   rs, rsp;
  logic        busy, done, we, re, rpo, oe, pfo;
  logic        sup = 0, pf = 0, cal = 0, e1 = 0, e2 = 0, man = 0;
  logic [15:0] ma;
  logic [1:0]  ts;
  logic [7:0]  wd, rd, ev;
  logic [7:0]  ex [5] = '{default: 8'h00};
  logic [15:0] pa [5] = '{16'h007f, 16'h0080, 16'h00ff, 16'h0100, 16'h01ff};
  int          prot [4] = '{0, 128, 256, 512};
  int          err_total = 0, tests_run = 0, cyc = 0, n;
  // Core clock, link clock at an odd phase
  always #20 clk = ~clk;
  initial begin
    #17;
    forever #80 lclk = ~lclk;
  end
  // Reset pin wire: driven low or manual switch
  assign pin = oe ? rpo : !man;
  psc_companion #(.HOLD_CYC(40), .STEP_CYC(20), .DEB_CYC(5), .CALH_CYC(8),
    .ARRAY_BYTES(512)) u_dut (
    .ref_clk_in(clk), .nrst_in(nrst), .link_clk_in(lclk),
    .link_req_in(req), .link_req_data_in(rq), .link_busy_out(busy),
    .link_done_out(done), .link_resp_out(rs), .mem_we_out(we),
    .mem_re_out(re), .mem_addr_out(ma), .mem_wdata_out(wd),
    .mem_rdata_in(rd), .supply_low_in(sup), .pf_below_in(pf),
    .calib_mode_in(cal), .event_in_one(e1), .event_in_two(e2),
    .rst_pin_in(pin), .rst_pin_out(rpo), .rst_pin_oe_out(oe),
    .trim_or_powerfail_out(pfo), .trip_select_out(ts));
  psc_mem_model u_mem (.clk_in(clk), .we_in(we), .re_in(re),
    .addr_in(ma), .wdata_in(wd), .rdata_out(rd));
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(logic c, logic w, logic [15:0] a, logic [7:0] d);
    @(negedge lclk);
    req = 1;
    rq = '{c, w, a, d};
    @(negedge lclk);
    req = 0;
    chk({7'h0, busy}, 8'h01);
    for (n = 0; n < 40 && done !== 1'b1; n++) @(negedge lclk);
    chk({6'h0, busy, done}, 8'h01);
    rsp = rs;
  endtask
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    acc(1'b1, 1'b1, {8'h00, a}, d);
  endtask
  task automatic rdc(logic [7:0] a, logic [7:0] e);
    acc(1'b1, 1'b0, {8'h00, a}, 8'h00);
    chk(rsp.rdata, e);
  endtask
  task automatic wait_oe(logic v, int lim);
    for (n = 0; n < lim && oe !== v; n++) @(negedge clk);
    chk({7'h0, oe}, {7'h0, v});
  endtask
  task automatic tog(int k);
    repeat (k) begin
      @(negedge clk);
      e1 = ~e1;
      e2 = ~e2;
      repeat (6) @(negedge clk);
    end
  endtask
  task automatic endt(string s);
    $display("test %s ends, mismatches so far %0d", s, err_total);
  endtask
  task automatic results;
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      results;
    end
  end
  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1;
    rdc(`PSC_OFF_DOG, 8'h1f);
    rdc(`PSC_OFF_FLAGS, 8'h40);
    rdc(8'h20, 8'h00);
    endt("reset");
    for (int m = 0; m < 4; m++) begin
      wreg(`PSC_OFF_CMP, 8'(m * 9));
      chk({6'h0, ts}, 8'(m));
      foreach (pa[i]) begin
        acc(1'b0, 1'b1, pa[i], 8'(m * 5 + i + 1));
        chk({7'h0, rsp.ack}, {7'h0, pa[i] >= prot[m]});
        if (pa[i] >= prot[m]) ex[i] = 8'(m * 5 + i + 1);
        acc(1'b0, 1'b0, pa[i], 8'h00);
        chk(rsp.rdata, ex[i]);
      end
    end
    endt("protect");
    wreg(`PSC_OFF_SER7, 8'h5a);
    rdc(`PSC_OFF_SER7, 8'h5a);
    wreg(`PSC_OFF_CMP, 8'h80);
    wreg(`PSC_OFF_SER7, 8'ha5);
    rdc(`PSC_OFF_SER7, 8'h5a);
    wreg(`PSC_OFF_CMP, 8'h00);
    rdc(`PSC_OFF_CMP, 8'h80);
    endt("serial");
    wreg(`PSC_OFF_CNTC, 8'h01);
    tog(5);
    wreg(`PSC_OFF_CNTC, 8'h09);
    tog(2);
    rdc(`PSC_OFF_CNT0, 8'h03);
    rdc(8'h0f, 8'h02);
    wreg(`PSC_OFF_CNTC, 8'h05);
    wreg(`PSC_OFF_CNT0, 8'hff);
    wreg(8'h0e, 8'hff);
    tog(2);
    wreg(`PSC_OFF_CNTC, 8'h0d);
    rdc(8'h0f, 8'h04);
    rdc(`PSC_OFF_CNT0, 8'h00);
    endt("counters");
    pf = 1;
    repeat (4) @(negedge clk);
    chk({7'h0, pfo}, 8'h00);
    cal = 1;
    repeat (4) @(negedge clk);
    ev = 0;
    pv = pfo;
    repeat (64) begin
      @(negedge clk);
      if (pfo !== pv) ev++;
      pv = pfo;
    end
    chk(ev, 8'h08);
    endt("powerfail");
    wreg(`PSC_OFF_FLAGS, 8'h00);
    sup = 1;
    repeat (4) @(negedge clk);
    chk({7'h0, oe}, 8'h01);
    wreg(`PSC_OFF_SER0, 8'h11);
    chk({7'h0, rsp.ack}, 8'h00);
    sup = 0;
    repeat (30) @(negedge clk);
    chk({7'h0, oe}, 8'h01);
    wait_oe(1'b0, 40);
    rdc(`PSC_OFF_FLAGS, 8'h40);
    endt("supply");
    wreg(`PSC_OFF_FLAGS, 8'h00);
    wreg(`PSC_OFF_DOG, 8'h05);
    wreg(`PSC_OFF_FLAGS, 8'h0a);
    wreg(`PSC_OFF_DOG, 8'h85);
    wait_oe(1'b1, 300);
    wait_oe(1'b0, 60);
    wreg(`PSC_OFF_DOG, 8'h1f);
    rdc(`PSC_OFF_FLAGS, 8'h80);
    endt("watchdog");
    wreg(`PSC_OFF_FLAGS, 8'h00);
    man = 1;
    wait_oe(1'b1, 20);
    man = 0;
    wait_oe(1'b0, 60);
    rdc(`PSC_OFF_FLAGS, 8'h00);
    endt("manual");
    results;
  end
endmodule
